// *** verilog/buck_setpoint_regs.sv ***
// register bank and set-point control for buck channel one
//
// What this block does
// - code n targets 300 mV plus n times 25
// - apply set point matching current operating mode
// - normal code in bits 5:0 at 0x20
// - standby code in bits 5:0 at 0x21
// - sleep code in bits 5:0 at 0x22
// - switching mode selector in bits 3:0 at 0x23
// - bit 5 selects sleep off or pulse-frequency
// - config bit 0 selects low current limit
// - config bits 3:2 select switching frequency
// - config bits 5:4 select clock phase
// - config bits 7:6 select voltage step speed
// - frequency codes 1, 2, 4 MHz, 11 reserved
// - phase codes 0, 90, 180, 270 degrees
// - step 25 mV every 2/4/8/16 us
`timescale 1ns/100ps
`include "buck_regs_params.svh"

module buck_setpoint_regs
  import buck_regs_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // register port from the two-wire control interface
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_RD,
  output logic      [7:0]  REG_RDATA,
  // operating mode from the power-state logic
  input  wire logic [1:0]  OP_MODE,
  // controls toward the regulator
  output logic      [5:0]  VOUT_CODE,
  output logic      [10:0] VOUT_MV,
  output logic             RAMP_BUSY,
  output logic             REG_ENABLE,
  output logic             PFM_FORCE,
  output logic      [3:0]  SW_MODE,
  output logic             ILIM_LOW,
  output logic      [1:0]  FREQ_SEL,
  output logic      [12:0] FREQ_KHZ,
  output logic             FREQ_RESERVED,
  output logic      [1:0]  PHASE_SEL,
  output logic      [8:0]  PHASE_DEG,
  output logic             SETPOINT_UNSUPPORTED
);

  setpoint_t   normal_q, normal_d;
  setpoint_t   standby_q, standby_d;
  setpoint_t   sleep_q, sleep_d;
  logic [3:0]  mode_q, mode_d;
  logic        sleep_beh_q, sleep_beh_d;
  logic [7:0]  config_q, config_d;
  logic [7:0]  rdata_q, rdata_d;
  setpoint_t   target_q, target_d;
  logic        enable_q, enable_d;
  logic        pfm_q, pfm_d;
  logic [10:0] mv_q, mv_d;
  logic        unsup_q, unsup_d;
  logic [12:0] khz_q, khz_d;
  logic [8:0]  deg_q, deg_d;
  logic        res_q, res_d;
  logic        stepping;
  setpoint_t   applied;

  function automatic logic [10:0] code_to_mv(input setpoint_t c);
    code_to_mv = `VOUT_BASE_MV + 11'(c) * `VOUT_STEP_MV;
  endfunction : code_to_mv

  function automatic logic [12:0] freq_to_khz(input logic [1:0] f);
    unique case (f)
      2'h0:    freq_to_khz = 13'h03E8;
      2'h1:    freq_to_khz = 13'h07D0;
      2'h2:    freq_to_khz = 13'h0FA0;
      default: freq_to_khz = 13'h0000;
    endcase
  endfunction : freq_to_khz

  function automatic logic [8:0] phase_to_deg(input logic [1:0] p);
    unique case (p)
      2'h0:    phase_to_deg = 9'h000;
      2'h1:    phase_to_deg = 9'h05A;
      2'h2:    phase_to_deg = 9'h0B4;
      default: phase_to_deg = 9'h10E;
    endcase
  endfunction : phase_to_deg

  // register writes and reads
  always_comb begin
    normal_d    = normal_q;
    standby_d   = standby_q;
    sleep_d     = sleep_q;
    mode_d      = mode_q;
    sleep_beh_d = sleep_beh_q;
    config_d    = config_q;
    rdata_d     = rdata_q;
    if (REG_WR) begin
      unique case (REG_ADDR)
        `ADDR_NORMAL_SETPOINT:  normal_d  = REG_WDATA[`SETPOINT_MSB:0];
        `ADDR_STANDBY_SETPOINT: standby_d = REG_WDATA[`SETPOINT_MSB:0];
        `ADDR_SLEEP_SETPOINT:   sleep_d   = REG_WDATA[`SETPOINT_MSB:0];
        `ADDR_SWITCHING_MODE: begin
          mode_d      = REG_WDATA[`MODE_FIELD_MSB:0];
          sleep_beh_d = REG_WDATA[`SLEEP_BEHAVIOUR_BIT];
        end
        `ADDR_REGULATOR_CONFIG: config_d = REG_WDATA;
        default: ;
      endcase
    end
    // read data is held until the next read; unused bits fill with zero, except spare config bit 1, which reads back as written
    if (REG_RD) begin
      unique case (REG_ADDR)
        `ADDR_NORMAL_SETPOINT:  rdata_d = {2'b00, normal_q};
        `ADDR_STANDBY_SETPOINT: rdata_d = {2'b00, standby_q};
        `ADDR_SLEEP_SETPOINT:   rdata_d = {2'b00, sleep_q};
        `ADDR_SWITCHING_MODE:   rdata_d = {2'b00, sleep_beh_q, 1'b0, mode_q};
        `ADDR_REGULATOR_CONFIG: rdata_d = config_q;
        default:                rdata_d = 8'h00;
      endcase
    end
  end

  // regulator-facing controls, all registered
  always_comb begin
    unique case (OP_MODE)
      OPMODE_STANDBY: target_d = standby_q;
      OPMODE_SLEEP:   target_d = sleep_q;
      default:        target_d = normal_q;
    endcase
    // sleep either shuts the channel off or forces pulse-frequency mode
    enable_d = !((OP_MODE == OPMODE_SLEEP) && !sleep_beh_q);
    pfm_d    = (OP_MODE == OPMODE_SLEEP) && sleep_beh_q;
    mv_d     = code_to_mv(applied);
    // hardware only flags the host slip; it still applies the code
    unsup_d  = (target_q < `LOWEST_SUPPORTED_CODE);
    khz_d    = freq_to_khz(config_q[`FREQ_LSB +: 2]);
    deg_d    = phase_to_deg(config_q[`PHASE_LSB +: 2]);
    res_d    = (config_q[`FREQ_LSB +: 2] == 2'h3);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      normal_q    <= `RST_SETPOINT;
      standby_q   <= `RST_SETPOINT;
      sleep_q     <= `RST_SETPOINT;
      mode_q      <= `RST_SWITCHING_MODE;
      sleep_beh_q <= `RST_SLEEP_BEHAVIOUR;
      config_q    <= `RST_CONFIG;
      rdata_q     <= 8'h00;
      target_q    <= `RST_SETPOINT;
      enable_q    <= 1'b1;
      pfm_q       <= 1'b0;
      mv_q        <= `VOUT_BASE_MV;
      unsup_q     <= 1'b1;
      khz_q       <= 13'h03E8;
      deg_q       <= 9'h000;
      res_q       <= 1'b0;
    end else begin
      normal_q    <= normal_d;
      standby_q   <= standby_d;
      sleep_q     <= sleep_d;
      mode_q      <= mode_d;
      sleep_beh_q <= sleep_beh_d;
      config_q    <= config_d;
      rdata_q     <= rdata_d;
      target_q    <= target_d;
      enable_q    <= enable_d;
      pfm_q       <= pfm_d;
      mv_q        <= mv_d;
      unsup_q     <= unsup_d;
      khz_q       <= khz_d;
      deg_q       <= deg_d;
      res_q       <= res_d;
    end
  end

  voltage_stepper #(
    .BASE_CYC (12'(`STEP_BASE_CYC))
  ) u_stepper (
    .clk    (CLK),
    .rst_n  (RSTN),
    .target (target_q),
    .speed  (config_q[`SPEED_LSB +: 2]),
    .busy   (stepping),
    .code   (applied)
  );

  assign REG_RDATA            = rdata_q;
  assign VOUT_CODE            = applied;
  assign VOUT_MV              = mv_q;
  assign RAMP_BUSY            = stepping;
  assign REG_ENABLE           = enable_q;
  assign PFM_FORCE            = pfm_q;
  assign SW_MODE              = mode_q;
  assign ILIM_LOW             = config_q[`ILIM_BIT];
  assign FREQ_SEL             = config_q[`FREQ_LSB +: 2];
  assign FREQ_KHZ             = khz_q;
  assign FREQ_RESERVED        = res_q;
  assign PHASE_SEL            = config_q[`PHASE_LSB +: 2];
  assign PHASE_DEG            = deg_q;
  assign SETPOINT_UNSUPPORTED = unsup_q;

  a_read_normal: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR == `ADDR_NORMAL_SETPOINT) |=> REG_RDATA == {2'b00, $past(normal_q)})
    else $error("normal set-point readback wrong");

  a_unused_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_RD && (REG_ADDR != `ADDR_REGULATOR_CONFIG) |=> REG_RDATA[7:6] == 2'b00)
    else $error("unused bits did not read zero");

  a_mode_readback: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == `ADDR_SWITCHING_MODE) ##1 REG_RD && !REG_WR &&
    (REG_ADDR == `ADDR_SWITCHING_MODE) |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h2F))
    else $error("mode register readback wrong");

  a_config_write: assert property (@(posedge CLK) disable iff (!RSTN)
    REG_WR && (REG_ADDR == `ADDR_REGULATOR_CONFIG) |=>
    (FREQ_SEL == $past(REG_WDATA[3:2])) && (ILIM_LOW == $past(REG_WDATA[0])))
    else $error("config write not applied");

  a_mode_select: assert property (@(posedge CLK) disable iff (!RSTN)
    (OP_MODE == OPMODE_STANDBY) && !REG_WR |=> target_q == $past(standby_q))
    else $error("standby set point not selected");

  a_sleep_off: assert property (@(posedge CLK) disable iff (!RSTN)
    (OP_MODE == OPMODE_SLEEP) && !sleep_beh_q |=> !REG_ENABLE && !PFM_FORCE)
    else $error("channel not off in sleep");

  a_mv_scale: assert property (@(posedge CLK) disable iff (!RSTN)
    1'b1 |=> VOUT_MV == 11'h12C + 11'($past(applied)) * 11'h019)
    else $error("millivolt target wrong");

  a_freq_decode: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(FREQ_SEL) == 2'h2 |-> FREQ_KHZ == 13'h0FA0)
    else $error("4 MHz code not decoded");

  a_phase_decode: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(PHASE_SEL) == 2'h3 |-> PHASE_DEG == 9'h10E)
    else $error("270 degree code not decoded");

  c_sleep_pfm: cover property (@(posedge CLK) disable iff (!RSTN) PFM_FORCE);

  c_reserved_freq: cover property (@(posedge CLK) disable iff (!RSTN) FREQ_RESERVED);

  c_mode_change: cover property (@(posedge CLK) disable iff (!RSTN)
    (OP_MODE == OPMODE_NORMAL) ##1 (OP_MODE == OPMODE_STANDBY));

endmodule : buck_setpoint_regs

// *** verilog/buck_regs_params.svh ***
// constants for the buck channel one set-point register bank
`ifndef BUCK_REGS_PARAMS_SVH
`define BUCK_REGS_PARAMS_SVH

// register addresses
`define ADDR_NORMAL_SETPOINT  8'h20
`define ADDR_STANDBY_SETPOINT 8'h21
`define ADDR_SLEEP_SETPOINT   8'h22
`define ADDR_SWITCHING_MODE   8'h23
`define ADDR_REGULATOR_CONFIG 8'h24

// reset values
`define RST_SETPOINT          6'h00
`define RST_SWITCHING_MODE    4'h0
`define RST_SLEEP_BEHAVIOUR   1'b0
`define RST_CONFIG            8'h00

// field positions
`define SETPOINT_MSB          5
`define MODE_FIELD_MSB        3
`define SLEEP_BEHAVIOUR_BIT   5
`define ILIM_BIT              0
`define SPARE_BIT             1
`define FREQ_LSB              2
`define PHASE_LSB             4
`define SPEED_LSB             6

// voltage coding in millivolts
`define VOUT_BASE_MV          11'h12C
`define VOUT_STEP_MV          11'h019
`define LOWEST_SUPPORTED_CODE 6'h0D

// timing: base voltage step interval and the clock period
`define CLK_PERIOD_PS         4000
`define STEP_BASE_NS          2000
`define STEP_BASE_CYC         ((`STEP_BASE_NS * 1000) / `CLK_PERIOD_PS)

`endif

// *** verilog/buck_regs_pkg.sv ***
// types shared by the buck channel one set-point register bank
package buck_regs_pkg;

  // operating mode reported by the power-state logic
  typedef enum logic [1:0] {
    OPMODE_NORMAL  = 2'h0,
    OPMODE_STANDBY = 2'h1,
    OPMODE_SLEEP   = 2'h2,
    OPMODE_SPARE   = 2'h3
  } op_mode_e;

  // voltage stepper state, one-hot
  typedef enum logic [1:0] {
    STEP_IDLE = 2'b01,
    STEP_RAMP = 2'b10
  } step_state_e;

  typedef logic [5:0] setpoint_t;

endpackage : buck_regs_pkg

// *** verilog/voltage_stepper.sv ***
// moves the applied set-point code one step at a time toward its target
`timescale 1ns/100ps
`include "buck_regs_params.svh"

module voltage_stepper
  import buck_regs_pkg::*;
#(
  parameter logic [11:0] BASE_CYC = 12'(`STEP_BASE_CYC)
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire setpoint_t target,
  input  wire logic [1:0] speed,
  output logic           busy,
  output setpoint_t      code
);

  step_state_e state_q, state_d;
  logic [11:0] cnt_q, cnt_d;
  setpoint_t   code_q, code_d;
  logic [11:0] period;

  // speed codes double the interval: base, 2x, 4x, 8x
  assign period = BASE_CYC << speed;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    code_d  = code_q;
    unique case (state_q)
      STEP_IDLE: begin
        cnt_d = 12'h000;
        if (target != code_q) begin
          state_d = STEP_RAMP;
        end
      end
      STEP_RAMP: begin
        if (target == code_q) begin
          state_d = STEP_IDLE;
          cnt_d   = 12'h000;
        end else if (cnt_q == period - 12'h001) begin
          // one 25 mV step per interval
          cnt_d  = 12'h000;
          code_d = (target > code_q) ? code_q + 6'h01 : code_q - 6'h01;
        end else begin
          cnt_d = cnt_q + 12'h001;
        end
      end
      default: begin
        state_d = STEP_IDLE;
        cnt_d   = 12'h000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= STEP_IDLE;
      cnt_q   <= 12'h000;
      code_q  <= `RST_SETPOINT;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      code_q  <= code_d;
    end
  end

  assign code = code_q;
  // the one-hot ramp bit keeps busy a plain flop output with no decode behind it
  assign busy = state_q[1];

  a_step_single: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(code_q) |-> (code_q == $past(code_q) + 6'h01) || (code_q == $past(code_q) - 6'h01))
    else $error("applied code moved by more than one step");

  a_step_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(code_q) |-> $past(cnt_q) == $past(period) - 12'h001)
    else $error("step taken before its interval elapsed");

  a_step_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (code_q == target) && $stable(target) |=> $stable(code_q))
    else $error("applied code moved while at target");

  c_ramp_up: cover property (@(posedge clk) disable iff (!rst_n)
    busy && (target > code_q) ##1 $changed(code_q));

  c_ramp_slow: cover property (@(posedge clk) disable iff (!rst_n)
    (speed == 2'h3) && $changed(code_q));

endmodule : voltage_stepper

// *** tb/host_model.sv ***
// host-side register master for the strobe port of the set-point bank
`timescale 1ns/100ps

module host_model (
  // clock
  input  wire logic       clk,
  // register port toward the bank
  output logic      [7:0] addr,
  output logic            wr,
  output logic      [7:0] wdata,
  output logic            rd
);
  initial begin
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
    rd    = 1'b0;
  end

  // one strobe per call; the bank takes it on the next rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = w;
    rd    = ~w;
    @(negedge clk);
    wr    = 1'b0;
    rd    = 1'b0;
    // released bus shows inverted values so stale data never looks live
    addr  = ~a;
    wdata = ~d;
  endtask : xfer

  // write then read the same address on the very next edge, no idle cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    rd    = 1'b0;
    @(negedge clk);
    wr    = 1'b0;
    rd    = 1'b1;
    @(negedge clk);
    rd    = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask : wr_rd
endmodule : host_model

// *** tb/tb_buck_setpoint_regs.sv ***
// self-checking bench for the buck channel one set-point register bank
`timescale 1ns/100ps

module tb_buck_setpoint_regs
  import buck_regs_pkg::*;
;
  logic        CLK, RSTN, REG_WR, REG_RD, RAMP_BUSY, REG_ENABLE, PFM_FORCE;
  logic        ILIM_LOW, FREQ_RESERVED, SETPOINT_UNSUPPORTED, rd_seen;
  logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, d;
  logic [1:0]  OP_MODE, FREQ_SEL, PHASE_SEL;
  logic [5:0]  VOUT_CODE;
  logic [10:0] VOUT_MV;
  logic [3:0]  SW_MODE;
  logic [12:0] FREQ_KHZ;
  logic [8:0]  PHASE_DEG;
  logic [7:0]  exp_q[$];
  logic [12:0] khz[4] = '{13'h03e8, 13'h07d0, 13'h0fa0, 13'h0000};
  int          fails, n_checks, n;

  buck_setpoint_regs i_dut (
    .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .OP_MODE(OP_MODE), .VOUT_CODE(VOUT_CODE), .VOUT_MV(VOUT_MV),
    .RAMP_BUSY(RAMP_BUSY), .REG_ENABLE(REG_ENABLE), .PFM_FORCE(PFM_FORCE),
    .SW_MODE(SW_MODE), .ILIM_LOW(ILIM_LOW), .FREQ_SEL(FREQ_SEL),
    .FREQ_KHZ(FREQ_KHZ), .FREQ_RESERVED(FREQ_RESERVED), .PHASE_SEL(PHASE_SEL),
    .PHASE_DEG(PHASE_DEG), .SETPOINT_UNSUPPORTED(SETPOINT_UNSUPPORTED)
  );

  host_model i_host (
    .clk(CLK), .addr(REG_ADDR), .wr(REG_WR), .wdata(REG_WDATA), .rd(REG_RD)
  );

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'b0, a, 8'h00);
  endtask : rd_exp

  task automatic settle;
    repeat (3) @(negedge CLK);
  endtask : settle

  // counts from the target change until the stepper goes idle again
  task automatic ramp(input int period, input int steps);
    n = 0;
    while (n < 20000 && !(n > 4 && RAMP_BUSY === 1'b0)) begin
      @(negedge CLK);
      n++;
    end
    chk("ramp_len", 13'(period * steps),
        (n >= period * steps && n <= period * steps + 6) ? 13'(period * steps) : 13'(n));
  endtask : ramp

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // read data is valid from the read edge on and is checked half a cycle later
  always @(posedge CLK) rd_seen <= REG_RD;
  initial forever begin
    @(negedge CLK);
    if (rd_seen === 1'b1)
      chk("REG_RDATA", {5'h00, exp_q.pop_front()}, {5'h00, REG_RDATA});
  end

  initial begin
    repeat (60000) @(posedge CLK);
    fails++;
    complete_run();
  end

  initial begin
    RSTN     = 1'b0;
    OP_MODE  = OPMODE_NORMAL;
    fails    = 0;
    n_checks = 0;
    void'($urandom(32'h39e0_8088));
    repeat (6) @(negedge CLK);
    RSTN = 1'b1;
    chk("VOUT_MV", 13'h012c, 13'(VOUT_MV));
    chk("FREQ_KHZ", 13'h03e8, FREQ_KHZ);
    chk("UNSUPPORTED", 13'h0001, 13'(SETPOINT_UNSUPPORTED));
    for (int a = 8'h20; a <= 8'h25; a++) rd_exp(8'(a), 8'h00);
    // normal ramp at the fastest speed, then a slower standby ramp
    i_host.xfer(1'b1, 8'h20, 8'hce);
    ramp(500, 14);
    chk("VOUT_CODE", 13'h000e, 13'(VOUT_CODE));
    chk("VOUT_MV", 13'h028a, 13'(VOUT_MV));
    chk("UNSUPPORTED", 13'h0000, 13'(SETPOINT_UNSUPPORTED));
    i_host.xfer(1'b1, 8'h24, 8'h40);
    i_host.xfer(1'b1, 8'h21, 8'h0f);
    OP_MODE = OPMODE_STANDBY;
    ramp(1000, 1);
    chk("VOUT_CODE", 13'h000f, 13'(VOUT_CODE));
    // sleep with the regulator off, then in pulse-frequency mode
    OP_MODE = OPMODE_SLEEP;
    settle();
    chk("REG_ENABLE", 13'h0000, 13'(REG_ENABLE));
    chk("UNSUPPORTED", 13'h0001, 13'(SETPOINT_UNSUPPORTED));
    i_host.xfer(1'b1, 8'h23, 8'h2a);
    settle();
    chk("REG_ENABLE", 13'h0001, 13'(REG_ENABLE));
    chk("PFM_FORCE", 13'h0001, 13'(PFM_FORCE));
    chk("SW_MODE", 13'h000a, 13'(SW_MODE));
    exp_q.push_back(8'h2f);
    i_host.wr_rd(8'h23, 8'hff);
    // the spare mode code must act as normal even with the sleep bit set
    OP_MODE = OPMODE_SPARE;
    settle();
    chk("PFM_FORCE", 13'h0000, 13'(PFM_FORCE));
    chk("REG_ENABLE", 13'h0001, 13'(REG_ENABLE));
    chk("SW_MODE", 13'h000f, 13'(SW_MODE));
    OP_MODE = OPMODE_NORMAL;
    settle();
    chk("PFM_FORCE", 13'h0000, 13'(PFM_FORCE));
    // every frequency and phase code, random speed and low bits
    for (int c = 0; c < 16; c++) begin
      d = {2'($urandom), 2'(c), 2'(c >> 2), 2'($urandom)};
      i_host.xfer(1'b1, 8'h24, d);
      settle();
      chk("ILIM_LOW", 13'(d[0]), 13'(ILIM_LOW));
      chk("FREQ_SEL", 13'(d[3:2]), 13'(FREQ_SEL));
      chk("FREQ_KHZ", khz[d[3:2]], FREQ_KHZ);
      chk("FREQ_RESERVED", 13'(d[3:2] == 2'h3), 13'(FREQ_RESERVED));
      chk("PHASE_SEL", 13'(d[5:4]), 13'(PHASE_SEL));
      chk("PHASE_DEG", 13'(d[5:4]) * 13'h005a, 13'(PHASE_DEG));
      rd_exp(8'h24, d);
    end
    // supported codes only, with random spare bits that must not stick
    for (int i = 0; i < 6; i++) begin
      d = {2'($urandom), 6'(13 + $urandom_range(50, 0))};
      i_host.xfer(1'b1, 8'(8'h20 + i % 3), d);
      rd_exp(8'(8'h20 + i % 3), {2'b00, d[5:0]});
    end
    i_host.xfer(1'b1, 8'h25, 8'($urandom));
    rd_exp(8'h25, 8'h00);
    settle();
    complete_run();
  end
endmodule : tb_buck_setpoint_regs
